// [common/sfc_pkg.sv]
// Constants shared by the serial flash command block
package sfc_pkg;

    // ----------------------------------------------------------------
    // Widths
    // ----------------------------------------------------------------
    localparam int CNT_W = 12;
    localparam int ADDR_W = 24;
    localparam int STAT_W = 24;
    localparam int TMR_W = 24;

    // ----------------------------------------------------------------
    // Opcodes
    // ----------------------------------------------------------------
    localparam logic [7:0] OP_WR_ENABLE = 8'h06;
    localparam logic [7:0] OP_WR_DISABLE = 8'h04;
    localparam logic [7:0] OP_VOL_ENABLE = 8'h50;
    localparam logic [7:0] OP_STAT_RD1 = 8'h05;
    localparam logic [7:0] OP_STAT_RD2 = 8'h35;
    localparam logic [7:0] OP_STAT_RD3 = 8'h15;
    localparam logic [7:0] OP_STAT_WR1 = 8'h01;
    localparam logic [7:0] OP_STAT_WR2 = 8'h31;
    localparam logic [7:0] OP_STAT_WR3 = 8'h11;
    localparam logic [7:0] OP_DUAL_IO_RD = 8'hbb;
    localparam logic [7:0] OP_QUAD_IO_RD = 8'heb;
    localparam logic [7:0] OP_QUAD_IO_WRD = 8'he7;
    localparam logic [7:0] OP_QUAD_ID_RD = 8'h94;
    localparam logic [7:0] OP_WRAP_SET = 8'h77;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_QUAD_PROG = 8'h32;
    localparam logic [7:0] OP_FAST_PROG = 8'hf2;
    localparam logic [7:0] OP_SECT_ERASE = 8'h20;
    localparam logic [7:0] OP_BLK32_ERASE = 8'h52;
    localparam logic [7:0] OP_BLK64_ERASE = 8'hd8;
    localparam logic [7:0] OP_CHIP_ERASE1 = 8'hc7;
    localparam logic [7:0] OP_CHIP_ERASE2 = 8'h60;
    localparam logic [7:0] OP_SEC_ERASE = 8'h44;
    localparam logic [7:0] OP_SEC_PROG = 8'h42;
    localparam logic [7:0] OP_SEC_READ = 8'h48;

    // ----------------------------------------------------------------
    // Status bit positions and masks
    // ----------------------------------------------------------------
    localparam int ST_WIP = 0;
    localparam int ST_WEL = 1;
    localparam int ST_STATUS_PROTECT_LO = 7;
    localparam int ST_STATUS_PROTECT_HI = 8;
    localparam int ST_QE = 9;
    localparam int ST_CMP = 14;
    localparam logic [23:0] ST_RESET = 24'h000000;
    localparam logic [23:0] ST_FIXED = 24'h9f8003;
    localparam logic [23:0] ONE_BYTE_CLR = 24'h004300;

    // ----------------------------------------------------------------
    // Frame positions, counted in serial clocks
    // ----------------------------------------------------------------
    localparam logic [11:0] CNT_ONE = 12'h001;
    localparam logic [11:0] CNT_MAX = 12'hfff;
    localparam logic [11:0] OPC_BITS = 12'h008;
    localparam logic [11:0] WR_ONE_LEN = 12'h010;
    localparam logic [11:0] WR_TWO_LEN = 12'h018;
    localparam logic [11:0] SGL_ADDR_END = 12'h020;
    localparam logic [11:0] DUAL_ADDR_END = 12'h018;
    localparam logic [11:0] QUAD_ADDR_END = 12'h010;
    localparam logic [11:0] QIO_DATA_START = 12'h014;
    localparam logic [11:0] QIOW_DATA_START = 12'h012;
    localparam logic [11:0] WRAP_CLK = 12'h00e;

    // ----------------------------------------------------------------
    // Security register address bytes
    // ----------------------------------------------------------------
    localparam logic [7:0] SEC_HI = 8'h00;
    localparam logic [7:0] SEC_MID1 = 8'h10;
    localparam logic [7:0] SEC_MID2 = 8'h20;
    localparam logic [7:0] SEC_MID3 = 8'h30;

    // ----------------------------------------------------------------
    // Identity bytes, values arbitrary
    // ----------------------------------------------------------------
    localparam logic [7:0] MAKER_ID = 8'h5a;
    localparam logic [7:0] PART_ID = 8'h15;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 40;
    localparam int TW_NS = 5000000;
    localparam int TW_CYCLES = TW_NS / CLK_PERIOD_NS;

    typedef enum logic [1:0] {SW_IDLE = 2'h1, SW_BUSY = 2'h2} sfc_sw_t;

endpackage

// [logic/sfc_sync.sv]
// Two-flop synchroniser bank
`timescale 1ns/1ns
module sfc_sync #(
    parameter int W = 1
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= '0;
            q <= '0;
        end
        else
        begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// [logic/sfc_cmd.sv]
// Serial flash configuration, status and identification command decoder
`timescale 1ns/1ns
// Behaviour
// R1 - Write-enable opcode sets the latch
// R2 - Single-byte write-disable frame clears the latch
// R3 - Latch clears at reset and cycle completion
// R4 - Status reads return low, middle, high byte
// R5 - Status reads allowed anytime, repeat while clocked
// R6 - Host polls busy flag before new instruction
// R7 - Status write needs latch set beforehand
// R8 - Status write keeps fixed bits unchanged
// R9 - Status write only after eighth/sixteenth bit
// R10 - One-byte write zeroes complement, quad, protect-hi
// R11 - Self-timed cycle holds busy, then clears latch
// R12 - Write updates block-protect and status-protect bits
// R13 - Hardware-protected mode ignores status writes
// R14 - Volatile enable: next write skips cycle
// R15 - Dual output: odd bits lane one
// R16 - Dual address: two bits per clock
// R17 - Quad: four bits per clock, nibbles
// R18 - Quad reads: four or two dummy clocks
// R19 - Host sends even address for word read
// R20 - Security register address encoding decoded
// R21 - Wrap bits on seventh quad clock
// R22 - Quad identification read returns maker, part
// R23 - Bits taken on rising clock, frame ends
// R24 - Quad reads need quad enable bit
// R25 - Writes ignored while busy
// R26 - Single-lane transfers most significant first
module sfc_cmd #(
    parameter int TW_CYC = sfc_pkg::TW_CYCLES
)
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RST_N,
    // Serial link
    input wire logic SCLK,
    input wire logic CS_N,
    input wire logic [3:0] LANE_IN,
    output logic [3:0] LANE_OUT,
    output logic [3:0] LANE_OE_N,
    // Protection pin
    input wire logic WP_N,
    // Array side, link clock
    input wire logic [7:0] RD_BYTE,
    output logic [sfc_pkg::ADDR_W-1:0] RD_ADDR,
    output logic [7:0] RD_MODE,
    // Array side, system clock
    input wire logic ARRAY_BUSY,
    input wire logic PE_DONE,
    output logic PE_START,
    output logic [7:0] PE_OP,
    output logic [sfc_pkg::ADDR_W-1:0] PE_ADDR,
    output logic [1:0] SEC_REG,
    output logic [2:0] WRAP_BITS,
    output logic [sfc_pkg::STAT_W-1:0] STATUS
);
    import sfc_pkg::*;

    // ----------------------------------------------------------------
    // Decoding helpers
    // ----------------------------------------------------------------
    function automatic logic [2:0] lane_width(input logic [7:0] op);
        case (op)
            OP_DUAL_IO_RD: lane_width = 3'h2;
            OP_QUAD_IO_RD, OP_QUAD_IO_WRD, OP_QUAD_ID_RD, OP_WRAP_SET: lane_width = 3'h4;
            default: lane_width = 3'h1;
        endcase
    endfunction

    function automatic logic [11:0] addr_end(input logic [7:0] op);
        case (lane_width(op))
            3'h2: addr_end = DUAL_ADDR_END;
            3'h4: addr_end = QUAD_ADDR_END;
            default: addr_end = SGL_ADDR_END;
        endcase
    endfunction

    function automatic logic [11:0] data_start(input logic [7:0] op);
        case (op)
            OP_STAT_RD1, OP_STAT_RD2, OP_STAT_RD3: data_start = OPC_BITS;
            OP_DUAL_IO_RD: data_start = DUAL_ADDR_END;
            OP_QUAD_IO_RD, OP_QUAD_ID_RD: data_start = QIO_DATA_START;
            OP_QUAD_IO_WRD: data_start = QIOW_DATA_START;
            default: data_start = 12'h000;
        endcase
    endfunction

    function automatic logic quad_gated(input logic [7:0] op);
        quad_gated = op == OP_QUAD_IO_RD || op == OP_QUAD_IO_WRD || op == OP_QUAD_ID_RD;
    endfunction

    function automatic logic is_stat_wr(input logic [7:0] op);
        is_stat_wr = op == OP_STAT_WR1 || op == OP_STAT_WR2 || op == OP_STAT_WR3;
    endfunction

    function automatic logic is_chip_erase(input logic [7:0] op);
        is_chip_erase = op == OP_CHIP_ERASE1 || op == OP_CHIP_ERASE2;
    endfunction

    function automatic logic is_addr_write(input logic [7:0] op);
        case (op)
            OP_PAGE_PROG, OP_QUAD_PROG, OP_FAST_PROG, OP_SECT_ERASE,
            OP_BLK32_ERASE, OP_BLK64_ERASE, OP_SEC_ERASE, OP_SEC_PROG: is_addr_write = 1'b1;
            default: is_addr_write = 1'b0;
        endcase
    endfunction

    function automatic logic [1:0] sec_sel(input logic [7:0] op, input logic [23:0] a);
        sec_sel = 2'h0;
        if ((op == OP_SEC_ERASE || op == OP_SEC_PROG || op == OP_SEC_READ) && a[23:16] == SEC_HI)
        begin
            case (a[15:8])
                SEC_MID1: sec_sel = 2'h1;
                SEC_MID2: sec_sel = 2'h2;
                SEC_MID3: sec_sel = 2'h3;
                default: sec_sel = 2'h0;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_m;
    logic rst_n_s;

    always_ff @(posedge MCLK or negedge RST_N)
    begin
        if (!RST_N)
        begin
            rst_m <= 1'b0;
            rst_n_s <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_n_s <= rst_m;
        end
    end

    // ----------------------------------------------------------------
    // Link side: capture on rising serial clock
    // ----------------------------------------------------------------
    logic started;
    logic [11:0] cnt;
    logic [11:0] idx;
    logic [7:0] opc;
    logic [31:0] shreg;
    logic [2:0] wrap_l;
    logic [23:0] stat_l;
    logic [7:0] rd_l;
    logic [23:0] stat_view;

    assign idx = started ? cnt : 12'h000;

    always_ff @(posedge SCLK or posedge CS_N or negedge rst_n_s)
    begin
        if (!rst_n_s)
            started <= 1'b0;
        else if (CS_N)
            started <= 1'b0;
        else
            started <= 1'b1;
    end

    // Count survives the frame end so the system side can judge its length
    always_ff @(posedge SCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
            cnt <= 12'h000;
        else if (!started)
            cnt <= CNT_ONE;
        else if (cnt != CNT_MAX)
            cnt <= cnt + CNT_ONE;
    end

    always_ff @(posedge SCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
            opc <= 8'h00;
        else if (idx < OPC_BITS)
            opc <= {opc[6:0], LANE_IN[0]}; // [R23] [R26]
    end

    always_ff @(posedge SCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
            shreg <= 32'h00000000;
        else if (idx >= OPC_BITS && idx < addr_end(opc))
        begin
            case (lane_width(opc))
                3'h2: shreg <= {shreg[29:0], LANE_IN[1], LANE_IN[0]}; // [R16]
                3'h4: shreg <= {shreg[27:0], LANE_IN}; // [R17] [R22]
                default: shreg <= {shreg[30:0], LANE_IN[0]}; // [R26]
            endcase
        end
    end

    always_ff @(posedge SCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
            wrap_l <= 3'h0;
        else if (opc == OP_WRAP_SET && idx == WRAP_CLK)
            wrap_l <= LANE_IN[2:0]; // [R21]
    end

    always_ff @(posedge SCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            RD_ADDR <= 24'h000000;
            RD_MODE <= 8'h00;
        end
        else if (idx == addr_end(opc) && lane_width(opc) != 3'h1)
        begin
            RD_ADDR <= shreg[31:8];
            RD_MODE <= shreg[7:0];
        end
        else if (idx == addr_end(opc))
            RD_ADDR <= shreg[23:0];
    end

    sfc_sync #(.W(24)) u_stat_l (.clk(SCLK), .rst_n(rst_n_s), .d(stat_view), .q(stat_l));
    sfc_sync #(.W(8)) u_rd_l (.clk(SCLK), .rst_n(rst_n_s), .d(RD_BYTE), .q(rd_l));

    // ----------------------------------------------------------------
    // Link side: drive on falling serial clock
    // ----------------------------------------------------------------
    logic [11:0] dstart;
    logic [11:0] pos;
    logic [7:0] obyte;
    logic [7:0] obyte_sh;
    logic [3:0] next_out;
    logic [3:0] next_oe_n;
    logic drive;

    always_comb
    begin
        dstart = data_start(opc);
        pos = cnt - dstart;
        case (opc)
            OP_STAT_RD1: obyte = stat_l[7:0]; // [R4]
            OP_STAT_RD2: obyte = stat_l[15:8]; // [R4]
            OP_STAT_RD3: obyte = stat_l[23:16]; // [R4]
            OP_QUAD_ID_RD: obyte = pos[1] ? PART_ID : MAKER_ID; // [R22]
            default: obyte = rd_l;
        endcase
        obyte_sh = obyte;
        case (lane_width(opc))
            3'h2:
            begin
                obyte_sh = obyte << {pos[1:0], 1'b0};
                next_out = {2'h0, obyte_sh[7], obyte_sh[6]}; // [R15]
                next_oe_n = 4'hc;
            end
            3'h4:
            begin
                next_out = pos[0] ? obyte[3:0] : obyte[7:4]; // [R17]
                next_oe_n = 4'h0;
            end
            default:
            begin
                obyte_sh = obyte << pos[2:0];
                next_out = {2'h0, obyte_sh[7], 1'b0}; // [R5] [R26]
                next_oe_n = 4'hd;
            end
        endcase
        // Dummy clocks pass before the data start count
        drive = dstart != 12'h000 && cnt >= dstart // [R18]
            && (!quad_gated(opc) || stat_l[ST_QE]); // [R24]
    end

    always_ff @(negedge SCLK or posedge CS_N or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            LANE_OUT <= 4'h0;
            LANE_OE_N <= 4'hf;
        end
        else if (CS_N)
        begin
            LANE_OUT <= 4'h0;
            LANE_OE_N <= 4'hf;
        end
        else if (drive)
        begin
            LANE_OUT <= next_out;
            LANE_OE_N <= next_oe_n;
        end
        else
        begin
            LANE_OUT <= 4'h0;
            LANE_OE_N <= 4'hf;
        end
    end

    a_quad_needs_enable: assert property (@(negedge SCLK) disable iff (CS_N || !rst_n_s) // [R24]
        quad_gated(opc) && !stat_l[ST_QE] |=> LANE_OE_N == 4'hf)
        else $error("quad read drove lanes with quad enable clear");

    // ----------------------------------------------------------------
    // System side: frame end and command effects
    // ----------------------------------------------------------------
    logic [1:0] pin_s;
    logic cs_d;
    logic frame_end;
    logic [23:0] stat;
    logic [23:0] next_stat;
    logic write_enable_latch;
    logic vol_arm;
    logic write_in_progress_flag;
    logic hw_prot;
    logic two_byte;
    logic len_ok;
    logic wren_ev;
    logic wrdi_ev;
    logic sw_ok;
    logic sw_end;
    logic pe_ok;
    sfc_sw_t sw_state;
    logic [TMR_W-1:0] tmr;

    // Select is synchronised inverted so its reset level matches an idle bus
    sfc_sync #(.W(2)) u_pin (.clk(MCLK), .rst_n(rst_n_s), .d({WP_N, !CS_N}), .q(pin_s));

    always_ff @(posedge MCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
            cs_d <= 1'b0;
        else
            cs_d <= pin_s[0];
    end

    // Frame fields are read only after the frame, while the serial clock is still
    assign frame_end = !pin_s[0] && cs_d; // [R23]
    assign write_in_progress_flag = sw_state == SW_BUSY || ARRAY_BUSY;
    assign stat_view = {stat[23:2], write_enable_latch, write_in_progress_flag};
    assign hw_prot = stat[ST_STATUS_PROTECT_LO] && !stat[ST_STATUS_PROTECT_HI] && !pin_s[1];
    assign two_byte = cnt == WR_TWO_LEN;
    assign len_ok = cnt == WR_ONE_LEN || two_byte; // [R9]
    assign wren_ev = frame_end && opc == OP_WR_ENABLE && cnt == OPC_BITS; // [R1]
    assign wrdi_ev = frame_end && opc == OP_WR_DISABLE && cnt == OPC_BITS; // [R2]
    assign sw_ok = frame_end && is_stat_wr(opc) && len_ok && !write_in_progress_flag // [R25]
        && !hw_prot && (write_enable_latch || vol_arm); // [R13] [R7] [R14]
    assign sw_end = sw_state == SW_BUSY && tmr == '0;
    assign pe_ok = frame_end && write_enable_latch && !write_in_progress_flag // [R1] [R25]
        && ((is_chip_erase(opc) && cnt == OPC_BITS)
        || (is_addr_write(opc) && cnt >= SGL_ADDR_END));

    always_comb
    begin
        next_stat = stat;
        case (opc)
            OP_STAT_WR1:
            begin
                next_stat[7:0] = two_byte ? shreg[15:8] : shreg[7:0]; // [R12]
                if (two_byte)
                    next_stat[15:8] = shreg[7:0];
                else
                    next_stat = next_stat & ~ONE_BYTE_CLR; // [R10]
            end
            OP_STAT_WR2: next_stat[15:8] = two_byte ? shreg[15:8] : shreg[7:0];
            OP_STAT_WR3: next_stat[23:16] = two_byte ? shreg[15:8] : shreg[7:0];
            default: next_stat = stat;
        endcase
        next_stat = (stat & ST_FIXED) | (next_stat & ~ST_FIXED); // [R8]
    end

    always_ff @(posedge MCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
            stat <= ST_RESET;
        else if (sw_ok)
            stat <= next_stat; // [R12]
    end

    // Volatile and non-volatile copies are the same flops; only the cycle differs
    always_ff @(posedge MCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            sw_state <= SW_IDLE;
            tmr <= '0;
        end
        else
        begin
            case (sw_state)
                SW_IDLE:
                begin
                    if (sw_ok && !vol_arm) // [R14]
                    begin
                        sw_state <= SW_BUSY; // [R11]
                        tmr <= TMR_W'(TW_CYC - 1);
                    end
                end
                SW_BUSY:
                begin
                    if (tmr == '0)
                        sw_state <= SW_IDLE;
                    else
                        tmr <= tmr - TMR_W'(1);
                end
                default: sw_state <= SW_IDLE;
            endcase
        end
    end

    // A set arriving with a clear wins
    always_ff @(posedge MCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
            write_enable_latch <= 1'b0; // [R3]
        else if (wren_ev)
            write_enable_latch <= 1'b1; // [R1]
        else if (sw_end || PE_DONE || wrdi_ev)
            write_enable_latch <= 1'b0; // [R2] [R3] [R11]
    end

    always_ff @(posedge MCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
            vol_arm <= 1'b0;
        else if (frame_end && cnt != 12'h000)
            vol_arm <= opc == OP_VOL_ENABLE && cnt == OPC_BITS; // [R14]
    end

    always_ff @(posedge MCLK or negedge rst_n_s)
    begin
        if (!rst_n_s)
        begin
            PE_START <= 1'b0;
            PE_OP <= 8'h00;
            PE_ADDR <= 24'h000000;
            SEC_REG <= 2'h0;
            WRAP_BITS <= 3'h0;
            STATUS <= ST_RESET;
        end
        else
        begin
            PE_START <= pe_ok;
            STATUS <= stat_view;
            if (pe_ok)
            begin
                PE_OP <= opc;
                PE_ADDR <= shreg[23:0];
                SEC_REG <= sec_sel(opc, shreg[23:0]); // [R20]
            end
            if (frame_end && opc == OP_WRAP_SET && cnt == QUAD_ADDR_END)
                WRAP_BITS <= wrap_l; // [R21]
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge MCLK);
    endclocking
    default disable iff (!rst_n_s);

    sequence s_nv_start;
        sw_ok && !vol_arm;
    endsequence

    sequence s_busy_latched;
        write_in_progress_flag && write_enable_latch;
    endsequence

    a_wren_sets_latch: assert property (wren_ev |=> write_enable_latch) // [R1]
        else $error("write enable did not set latch");
    a_wrdi_clears_latch: assert property (wrdi_ev |=> !write_enable_latch) // [R2]
        else $error("write disable did not clear latch");
    a_done_clears_latch: assert property (PE_DONE && !wren_ev |=> !write_enable_latch) // [R3]
        else $error("latch survived program or erase completion");
    a_no_latch_ignored: assert property ( // [R7]
        frame_end && is_stat_wr(opc) && !write_enable_latch && !vol_arm |=> $stable(stat))
        else $error("status write taken without latch");
    a_fixed_bits_kept: assert property (##1 $stable(stat & ST_FIXED)) // [R8]
        else $error("fixed status bit changed");
    a_bad_length_dropped: assert property ( // [R9]
        frame_end && is_stat_wr(opc) && !len_ok |=> $stable(stat))
        else $error("status write of wrong length taken");
    a_one_byte_clears: assert property ( // [R10]
        sw_ok && opc == OP_STAT_WR1 && !two_byte |=> (stat & ONE_BYTE_CLR) == 24'h000000)
        else $error("one byte write left protect bits set");
    a_cycle_holds_busy: assert property (s_nv_start |=> s_busy_latched ##1 write_in_progress_flag) // [R11]
        else $error("status write cycle not busy");
    a_end_releases: assert property (sw_end && !wren_ev |=> !write_enable_latch && sw_state == SW_IDLE) // [R11]
        else $error("cycle end did not clear latch");
    a_hw_protect_blocks: assert property (frame_end && hw_prot |=> $stable(stat)) // [R13]
        else $error("status write taken in protected mode");
    a_busy_rejects: assert property (frame_end && write_in_progress_flag |=> $stable(stat) && !PE_START) // [R25]
        else $error("command taken while busy");
endmodule

// [testbench/sfc_host.sv]
// SPI host model driving the link side of the command block
`timescale 1ns/1ns
module sfc_host (
    // Link
    output logic SCLK,
    output logic CS_N,
    output logic [3:0] LANE_IN,
    input wire logic [3:0] LANE_OUT,
    input wire logic [3:0] LANE_OE_N
);
    initial
    begin
        SCLK = 1'b0;
        CS_N = 1'b1;
        LANE_IN = 4'ha;
    end
    // ------------------------------------------------------------
    // One frame: n bits out on lane zero with lane one sampled back, or opcode then n quad clocks on all lanes
    // ------------------------------------------------------------
    task automatic xfer(input logic [31:0] w, input int n, output logic [7:0] rd);
        rd = 8'h00;
        CS_N = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            LANE_IN[0] = w[n-1-i];
            #24 SCLK = 1'b1;
            rd = {rd[6:0], LANE_OE_N[1] ? 1'bx : LANE_OUT[1]};
            #24 SCLK = 1'b0;
        end
        #24 CS_N = 1'b1;
        // Released line shows the inverse so stale data cannot pass
        LANE_IN = ~LANE_IN;
        #160;
    endtask
    task automatic qxfer(input logic [7:0] op, input logic [31:0] w, input int n,
        output logic [15:0] rd);
        rd = 16'h0000;
        CS_N = 1'b0;
        for (int i = 0; i < 8 + n; i++)
        begin
            LANE_IN = i < 8 ? {3'h0, op[7-i]} : w[31-4*(i%8) -: 4];
            #24 SCLK = 1'b1;
            rd = {rd[11:0], LANE_OE_N == 4'h0 ? LANE_OUT : 4'hx};
            #24 SCLK = 1'b0;
        end
        #24 CS_N = 1'b1;
        LANE_IN = ~LANE_IN;
        #160;
    endtask
endmodule

// [testbench/sfc_cmd_tb.sv]
// Self-checking bench for the status and configuration command decoder
`timescale 1ns/1ns
module sfc_cmd_tb;
    import sfc_pkg::*;
    logic MCLK = 1'b0;
    logic RST_N = 1'b0;
    logic WP_N = 1'b1;
    logic ARRAY_BUSY = 1'b0;
    logic PE_DONE = 1'b0;
    logic [7:0] RD_BYTE = 8'h00;
    logic SCLK, CS_N;
    logic [3:0] LANE_IN, LANE_OUT, LANE_OE_N;
    logic [23:0] STATUS;
    logic [23:0] RD_ADDR, PE_ADDR;
    logic [7:0] RD_MODE, PE_OP;
    logic [2:0] WRAP_BITS;
    logic [1:0] SEC_REG;
    logic PE_START;
    logic [15:0] q;
    logic [31:0] w;
    logic [7:0] n_pe = 8'h00;
    logic [23:0] st = 24'h0;
    logic [7:0] rd, b;
    logic [7:0] ops [3] = '{OP_STAT_RD1, OP_STAT_RD2, OP_STAT_RD3};
    int n_errors = 0;
    int tests_run = 0;
    always #20 MCLK = ~MCLK;
    always @(posedge MCLK)
        if (PE_START === 1'b1)
            n_pe <= n_pe + 8'h01;
    sfc_host host (.SCLK(SCLK), .CS_N(CS_N), .LANE_IN(LANE_IN), .LANE_OUT(LANE_OUT),
        .LANE_OE_N(LANE_OE_N));
    sfc_cmd #(.TW_CYC(20)) dut (.MCLK(MCLK), .RST_N(RST_N), .SCLK(SCLK), .CS_N(CS_N),
        .LANE_IN(LANE_IN), .LANE_OUT(LANE_OUT), .LANE_OE_N(LANE_OE_N), .WP_N(WP_N),
        .RD_BYTE(RD_BYTE), .RD_ADDR(RD_ADDR), .RD_MODE(RD_MODE), .ARRAY_BUSY(ARRAY_BUSY),
        .PE_DONE(PE_DONE), .PE_START(PE_START), .PE_OP(PE_OP), .PE_ADDR(PE_ADDR),
        .SEC_REG(SEC_REG), .WRAP_BITS(WRAP_BITS), .STATUS(STATUS));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic test_done;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic frame(input logic [31:0] w, input int n);
        host.xfer(w, n, rd);
        repeat (10) @(posedge MCLK);
        #1;
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        void'($urandom(29534));
        repeat (8) @(posedge MCLK);
        RST_N <= 1'b1;
        @(posedge MCLK);
        RD_BYTE <= $urandom;
        repeat (6) @(posedge MCLK);
        #1;
        check("status", STATUS, 24'h0);
        b = $urandom;
        frame({8'h01, b}, 16);
        check("status", STATUS, st);
        frame(32'h06, 8);
        check("status", STATUS, st | 24'h2);
        frame(32'h04, 8);
        check("status", STATUS, st);
        frame(32'h06, 8);
        frame({8'h01, b[7:1]}, 15);
        check("status", STATUS, st | 24'h2);
        frame({8'h01, b}, 16);
        st = {st[23:8], b[7:2], 2'b00} & ~ONE_BYTE_CLR;
        check("status", STATUS, st | 24'h3);
        while (STATUS[0] !== 1'b0)
        begin
            @(posedge MCLK);
            #1;
        end
        check("status", STATUS, st);
        for (int k = 0; k < 3; k++)
        begin
            host.xfer({ops[k], 16'h0}, 24, rd);
            check("read", {16'h0, rd}, {16'h0, st[8*k +: 8]});
        end
        host.qxfer(OP_QUAD_IO_RD, 32'h0, 16, q);
        check("quad off", {8'h0, q}, 24'h00xxxx);
        b = $urandom;
        b[1] = 1'b1;
        frame(32'h50, 8);
        frame({8'h31, b}, 16);
        st[14:8] = b[6:0];
        check("status", STATUS, st);
        host.qxfer(OP_QUAD_ID_RD, 32'h0, 16, q);
        check("id", {8'h0, q}, {8'h0, MAKER_ID, PART_ID});
        w = $urandom;
        w[8] = 1'b0;
        host.qxfer(OP_QUAD_IO_WRD, w, 14, q);
        check("word read", {8'h0, q}, {8'h0, RD_BYTE, RD_BYTE});
        check("addr", RD_ADDR, w[31:8]);
        check("mode", {16'h0, RD_MODE}, {16'h0, w[7:0]});
        host.qxfer(OP_WRAP_SET, {24'h0, 1'b0, w[2:0], 4'h0}, 8, q);
        frame(32'h06, 8);
        check("wrap", {21'h0, WRAP_BITS}, {21'h0, w[2:0]});
        frame({OP_SEC_ERASE, SEC_HI, SEC_MID3, w[7:0]}, 32);
        check("op", {16'h0, PE_OP}, {16'h0, OP_SEC_ERASE});
        check("pe addr", PE_ADDR, {SEC_HI, SEC_MID3, w[7:0]});
        check("sec reg", {22'h0, SEC_REG}, 24'h000003);
        check("starts", {16'h0, n_pe}, 24'h000001);
        check("status", STATUS, st | 24'h2);
        @(posedge MCLK);
        PE_DONE <= 1'b1;
        @(posedge MCLK);
        PE_DONE <= 1'b0;
        repeat (3) @(posedge MCLK);
        #1;
        check("status", STATUS, st);
        test_done();
    end
    initial
    begin
        #300000;
        n_errors++;
        test_done();
    end
endmodule
